// ===== src/osdco_ornament.sv
`timescale 1ns/1ps
`include "osdco_cfg.svh"

module osdco_ornament
    import osdco_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        dotValid,
    input  wire logic [3:0]  dotRow,
    input  wire logic [4:0]  dotCol,
    input  wire logic        cellLeft,
    input  wire logic        cellRight,
    input  wire logic        cellTop,
    input  wire logic        cellBottom,
    input  wire logic        glyphC,
    input  wire logic        glyphN,
    input  wire logic        glyphS,
    input  wire logic        glyphE,
    input  wire logic        glyphW,
    input  wire logic        ulineDot,
    input  wire logic        colorFont,
    input  wire logic [2:0]  charColor,
    input  wire logic        slantAttr,
    input  wire logic        underlineAttr,
    input  wire logic        charBgEnable,
    input  wire logic        areaOn,
    input  wire logic [2:0]  areaColor,
    output logic             pixValid,
    output osdco_pix_sel_t   pixSel,
    output logic      [2:0]  pixCode,
    output logic      [5:0]  pixRgb,
    output osdco_row_mode_t  rowMode,
    output logic      [5:0]  rowPitch
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic osdco_row_mode_t decodeRow(input logic [1:0] sz,
                                                  input logic       dbl,
                                                  input logic       tall);
        osdco_row_mode_t m;
        m = OSDCO_ROW_OFF;
        unique case (sz)
            2'h3: m = tall ? OSDCO_ROW_TALL : OSDCO_ROW_SMALL;
            2'h2: m = dbl ? OSDCO_ROW_DOUBLE : OSDCO_ROW_MEDIUM;
            2'h1: m = OSDCO_ROW_LARGE;
            2'h0: m = OSDCO_ROW_OFF;
        endcase
        return m;
    endfunction

    function automatic logic [5:0] pitchOf(input osdco_row_mode_t m);
        logic [5:0] p;
        p = `OSDCO_PITCH_SMALL;
        unique case (m)
            OSDCO_ROW_OFF:    p = `OSDCO_PITCH_SMALL;
            OSDCO_ROW_SMALL:  p = `OSDCO_PITCH_SMALL;
            OSDCO_ROW_MEDIUM: p = `OSDCO_PITCH_MEDIUM;
            OSDCO_ROW_LARGE:  p = `OSDCO_PITCH_LARGE;
            OSDCO_ROW_DOUBLE: p = `OSDCO_PITCH_MEDIUM;
            OSDCO_ROW_TALL:   p = `OSDCO_PITCH_TALL;
        endcase
        return p;
    endfunction

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [7:0]  ornament_q;
    logic [7:0]  fringeLow_q;
    logic [3:0]  fringeHigh_q;
    logic [7:0]  colorSel_q;
    logic [11:0] doubleRows_q;
    logic [11:0] tallRows_q;
    logic [7:0]  raster_q;
    logic [7:0]  display_q;
    logic [23:0] rowSize_q;
    logic [5:0]  palette_q [0:7];
    logic        waitReq_q;
    logic [31:0] readData_q;

    logic        wrTake;
    logic        reqFirst;
    logic [11:0] lineFringe;
    logic        smoothEn;
    logic        screenBgEn;
    logic        charBgSel;

    assign wrTake     = avs_write && !waitReq_q;
    assign reqFirst   = (avs_read || avs_write) && waitReq_q;
    assign lineFringe = {fringeHigh_q, fringeLow_q};
    assign smoothEn   = ornament_q[`OSDCO_SMOOTH_BIT];
    assign screenBgEn = raster_q[`OSDCO_SCREEN_BG_BIT];
    assign charBgSel  = display_q[`OSDCO_CHAR_BG_SEL_BIT];

    // One wait cycle per access; master sees waitrequest low on the next edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitReq_q <= 1'b1;
        end else if (reqFirst) begin
            waitReq_q <= 1'b0;
        end else begin
            waitReq_q <= 1'b1;
        end
    end

    // Writes land in the same edge that completes the transfer, no transfer strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ornament_q   <= `OSDCO_RST_BYTE;
            fringeLow_q  <= `OSDCO_RST_BYTE;
            fringeHigh_q <= 4'h0;
            colorSel_q   <= `OSDCO_RST_BYTE;
            doubleRows_q <= `OSDCO_RST_ROWS;
            tallRows_q   <= `OSDCO_RST_ROWS;
            raster_q     <= `OSDCO_RST_BYTE;
            display_q    <= `OSDCO_RST_BYTE;
            rowSize_q    <= `OSDCO_RST_SIZE;
        end else if (wrTake) begin
            unique case (avs_address)
                `OSDCO_OFS_ORNAMENT:    ornament_q   <= avs_writedata[7:0];
                `OSDCO_OFS_FRINGE_LOW:  fringeLow_q  <= avs_writedata[7:0];
                `OSDCO_OFS_FRINGE_HIGH: fringeHigh_q <= avs_writedata[3:0];
                `OSDCO_OFS_COLOR:       colorSel_q   <= avs_writedata[7:0];
                `OSDCO_OFS_DOUBLE:      doubleRows_q <= avs_writedata[11:0];
                `OSDCO_OFS_TALL:        tallRows_q   <= avs_writedata[11:0];
                `OSDCO_OFS_RASTER:      raster_q     <= avs_writedata[7:0];
                `OSDCO_OFS_DISPLAY:     display_q    <= avs_writedata[7:0];
                `OSDCO_OFS_ROW_SIZE:    rowSize_q    <= avs_writedata[23:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                palette_q[i] <= `OSDCO_RST_PAL;
            end
        end else if (wrTake && avs_address[7:5] == `OSDCO_OFS_PALETTE >> 5
                     && avs_address[1:0] == 2'h0) begin
            palette_q[avs_address[4:2]] <= avs_writedata[5:0];
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readData_q <= 32'h0;
        end else if (reqFirst && avs_read) begin
            readData_q <= 32'h0;
            unique case (avs_address)
                `OSDCO_OFS_ORNAMENT:    readData_q <= {24'h0, ornament_q};
                `OSDCO_OFS_FRINGE_LOW:  readData_q <= {24'h0, fringeLow_q};
                `OSDCO_OFS_FRINGE_HIGH: readData_q <= {28'h0, fringeHigh_q};
                `OSDCO_OFS_COLOR:       readData_q <= {24'h0, colorSel_q};
                `OSDCO_OFS_DOUBLE:      readData_q <= {20'h0, doubleRows_q};
                `OSDCO_OFS_TALL:        readData_q <= {20'h0, tallRows_q};
                `OSDCO_OFS_RASTER:      readData_q <= {24'h0, raster_q};
                `OSDCO_OFS_DISPLAY:     readData_q <= {24'h0, display_q};
                `OSDCO_OFS_ROW_SIZE:    readData_q <= {8'h0, rowSize_q};
                `OSDCO_OFS_STATUS:      readData_q <= {20'h0, rowMode, pixSel};
                default: begin
                    if (avs_address[7:5] == `OSDCO_OFS_PALETTE >> 5
                        && avs_address[1:0] == 2'h0) begin
                        readData_q <= {26'h0, palette_q[avs_address[4:2]]};
                    end
                end
            endcase
        end
    end

    assign avs_waitrequest = waitReq_q;
    assign avs_readdata    = readData_q;

    // ****************************************************************
    // Per-dot ornament decision
    // ****************************************************************
    logic            rowOk;
    osdco_row_mode_t curMode;
    logic            maskW;
    logic            maskE;
    logic            fringeSrc;
    logic            fringeHit;
    logic            smoothHit;
    logic            smoothOk;
    logic [2:0]      bgCode;
    osdco_pix_sel_t  sel_d;
    logic [2:0]      code_d;

    assign rowOk   = dotRow < 4'(`OSDCO_ROWS);
    assign curMode = rowOk ? decodeRow(rowSize_q[{dotRow, 1'b0} +: 2],
                                       doubleRows_q[dotRow], tallRows_q[dotRow])
                           : OSDCO_ROW_OFF;

    // Screen edges stop the side spill; inner left/right borders let it pass, top/bottom borders stop it
    assign maskW = cellLeft && dotCol == 5'h00;
    assign maskE = cellRight && dotCol == `OSDCO_LAST_COL;
    assign fringeSrc = (glyphW && !maskW) || (glyphE && !maskE)
                    || (glyphN && !cellTop) || (glyphS && !cellBottom);
    // Underline dots neither take nor cast a fringe
    assign fringeHit = rowOk && lineFringe[dotRow] && !glyphC
                       && !ulineDot && fringeSrc;

    // Small rows and colour font never smoothed; one page-wide switch
    assign smoothOk  = smoothEn && !colorFont
                       && curMode != OSDCO_ROW_SMALL
                       && curMode != OSDCO_ROW_TALL;
    assign smoothHit = smoothOk && !glyphC && ((glyphN && glyphE) || (glyphE && glyphS)
                       || (glyphS && glyphW) || (glyphW && glyphN));

    // Select bit: blue forced low, so only even palette entries remain
    assign bgCode = charBgSel ? {slantAttr, underlineAttr, 1'b0}
                              : colorSel_q[`OSDCO_BG_COL_LSB +: 3];

    always_comb begin
        sel_d  = OSDCO_PIX_VIDEO;
        code_d = 3'h0;
        if (curMode == OSDCO_ROW_OFF) begin
            sel_d = areaOn ? OSDCO_PIX_AREA : OSDCO_PIX_VIDEO;
            code_d = areaColor;
        end else if (glyphC || ulineDot) begin
            sel_d  = OSDCO_PIX_CHAR;
            code_d = charColor;
        end else if (fringeHit) begin
            sel_d  = OSDCO_PIX_FRINGE;
            code_d = colorSel_q[`OSDCO_FRINGE_COL_LSB +: 3];
        end else if (smoothHit) begin
            sel_d  = OSDCO_PIX_SMOOTH;
            code_d = charColor;
        end else if (screenBgEn && charBgEnable) begin
            sel_d  = OSDCO_PIX_BACK;
            code_d = bgCode;
        end else if (!screenBgEn && charBgEnable && areaOn) begin
            sel_d  = OSDCO_PIX_AREA;
            code_d = areaColor;
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pixValid <= 1'b0;
            pixSel   <= OSDCO_PIX_VIDEO;
            pixCode  <= 3'h0;
            pixRgb   <= `OSDCO_RST_PAL;
        end else begin
            pixValid <= dotValid;
            if (dotValid) begin
                pixSel  <= sel_d;
                pixCode <= code_d;
                pixRgb  <= palette_q[code_d];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rowMode  <= OSDCO_ROW_OFF;
            rowPitch <= `OSDCO_PITCH_SMALL;
        end else if (dotValid) begin
            rowMode  <= curMode;
            rowPitch <= pitchOf(curMode);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    smooth_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wrTake && avs_address == `OSDCO_OFS_ORNAMENT
        |=> smoothEn == $past(avs_writedata[`OSDCO_SMOOTH_BIT]))
        else $error("smoothing bit did not follow the write");

    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        reqFirst |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one wait cycle");

    font_smooth_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid && colorFont |=> pixSel != OSDCO_PIX_SMOOTH)
        else $error("colour font was smoothed");

    fringe_color_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid ##1 pixSel == OSDCO_PIX_FRINGE
        |-> pixCode == $past(colorSel_q[2:0]))
        else $error("fringe not in fringe colour");

    dot_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid && glyphC && curMode != OSDCO_ROW_OFF
        |=> pixSel == OSDCO_PIX_CHAR && pixCode == $past(charColor))
        else $error("active dot lost to fringe");

    edge_spill_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid && maskW && !glyphE && !glyphN && !glyphS
        |=> pixSel != OSDCO_PIX_FRINGE)
        else $error("fringe spilled past left edge");

    vert_fringe_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid && cellTop && cellBottom && !glyphW && !glyphE
        |=> pixSel != OSDCO_PIX_FRINGE)
        else $error("fringe outside the cell vertically");

    uline_fringe_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid && ulineDot |=> pixSel inside {OSDCO_PIX_CHAR, OSDCO_PIX_VIDEO,
                                                 OSDCO_PIX_AREA})
        else $error("underline got a fringe");

    back_show_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid ##1 pixSel == OSDCO_PIX_BACK
        |-> $past(screenBgEn && charBgEnable))
        else $error("background shown without both enables");

    tall_pitch_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid && curMode == OSDCO_ROW_TALL
        |=> rowPitch == `OSDCO_PITCH_TALL)
        else $error("tall small row pitch wrong");

    double_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        dotValid && rowOk && rowSize_q[{dotRow, 1'b0} +: 2] == 2'h2 && doubleRows_q[dotRow]
        |=> rowMode == OSDCO_ROW_DOUBLE)
        else $error("double height not selected");

endmodule

// ===== src/osdco_cfg.svh
// Function
// - Page smoothing enable at bit 4, ornament control
// - Smoothing bit acts at the write
// - Colour font characters are never smoothed
// - Fringe one dot wide, fringe colour
// - Full cell fringe spills into neighbour cells
// - No fringe above or below the cell
// - Neighbour active edge dot beats spilled fringe
// - Underline dots are never fringed
// - Twelve line fringe enables, 8 plus 4
// - Shared fringe colour in bits 2..0
// - No spill past first or 32nd column
// - Code 10 plus double bit: double height
// - Twelve double height bits in one register
// - Code 11 plus tall bit: 26 line pitch
// - Twelve 26-line bits in one register
// - Screen enable bit 7, character select bit 3
// - Both enables show colour; char only transparent
// - Background colour in bits 6..4
// - Select bit: slant, underline give red, green
// - Smoothing never on small, page wide
// - Size codes: 11 small, 10 medium, 01 large, 00 off
`ifndef OSDCO_CFG_SVH
`define OSDCO_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OSDCO_OFS_ORNAMENT     8'h00
`define OSDCO_OFS_FRINGE_LOW   8'h04
`define OSDCO_OFS_FRINGE_HIGH  8'h08
`define OSDCO_OFS_COLOR        8'h0c
`define OSDCO_OFS_DOUBLE       8'h10
`define OSDCO_OFS_TALL         8'h14
`define OSDCO_OFS_RASTER       8'h18
`define OSDCO_OFS_DISPLAY      8'h1c
`define OSDCO_OFS_ROW_SIZE     8'h20
`define OSDCO_OFS_STATUS       8'h24
`define OSDCO_OFS_PALETTE      8'h40

// ****************************************************************
// Field positions
// ****************************************************************
`define OSDCO_SMOOTH_BIT       4
`define OSDCO_SCREEN_BG_BIT    7
`define OSDCO_CHAR_BG_SEL_BIT  3
`define OSDCO_FRINGE_COL_LSB   0
`define OSDCO_BG_COL_LSB       4

// ****************************************************************
// Reset values
// ****************************************************************
`define OSDCO_RST_BYTE         8'h00
`define OSDCO_RST_ROWS         12'h000
`define OSDCO_RST_SIZE         24'h000000
`define OSDCO_RST_PAL          6'h00

// ****************************************************************
// Row pitch in scanning lines
// ****************************************************************
`define OSDCO_PITCH_SMALL      6'h09
`define OSDCO_PITCH_MEDIUM     6'h12
`define OSDCO_PITCH_LARGE      6'h24
`define OSDCO_PITCH_TALL       6'h1a
`define OSDCO_ROWS             12
`define OSDCO_LAST_COL         5'h1f

`endif

// ===== src/osdco_pkg.sv
package osdco_pkg;

    typedef enum logic [5:0] {
        OSDCO_ROW_OFF    = 6'h01,
        OSDCO_ROW_SMALL  = 6'h02,
        OSDCO_ROW_MEDIUM = 6'h04,
        OSDCO_ROW_LARGE  = 6'h08,
        OSDCO_ROW_DOUBLE = 6'h10,
        OSDCO_ROW_TALL   = 6'h20
    } osdco_row_mode_t;

    typedef enum logic [5:0] {
        OSDCO_PIX_VIDEO  = 6'h01,
        OSDCO_PIX_CHAR   = 6'h02,
        OSDCO_PIX_SMOOTH = 6'h04,
        OSDCO_PIX_FRINGE = 6'h08,
        OSDCO_PIX_BACK   = 6'h10,
        OSDCO_PIX_AREA   = 6'h20
    } osdco_pix_sel_t;

endpackage

// ===== bench/osdco_video_sink.sv
`timescale 1ns/1ps

// ****************************************************************
// Video mixer side: counts pixels it is handed
// ****************************************************************
module osdco_video_sink (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pixValid,
    output int        pixCount
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pixCount <= 0;
        end else if (pixValid) begin
            pixCount <= pixCount + 1;
        end
    end
endmodule

// ===== bench/osdco_ornament_tb.sv
`timescale 1ns/1ps
`include "osdco_cfg.svh"

module osdco_ornament_tb;
    import osdco_pkg::*;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, dotValid, pixValid;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, q, r;
    logic [3:0] dotRow;
    logic [4:0] dotCol;
    logic cellLeft, cellRight, cellTop, cellBottom, glyphC, glyphN, glyphS, glyphE, glyphW;
    logic ulineDot, colorFont, slantAttr, underlineAttr, charBgEnable, areaOn;
    logic [2:0] charColor, areaColor, pixCode, fcol, bcol;
    logic [5:0] pixRgb, rowPitch, pal [8];
    osdco_pix_sel_t pixSel;
    osdco_row_mode_t rowMode;
    logic [11:0] frRows, dblRows, tallRows;
    logic smoothOn, scrBg, selBg;
    logic [27:0] expQ [$];
    logic [27:0] e;
    int err_count, n_checks, pixCount, sent;
    int csz [12] = '{2, 2, 2, 1, 1, 3, 3, 0, 2, 3, 2, 1};

    osdco_ornament dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dotValid(dotValid), .dotRow(dotRow), .dotCol(dotCol), .cellLeft(cellLeft),
        .cellRight(cellRight), .cellTop(cellTop), .cellBottom(cellBottom), .glyphC(glyphC),
        .glyphN(glyphN), .glyphS(glyphS), .glyphE(glyphE), .glyphW(glyphW),
        .ulineDot(ulineDot), .colorFont(colorFont), .charColor(charColor),
        .slantAttr(slantAttr), .underlineAttr(underlineAttr), .charBgEnable(charBgEnable),
        .areaOn(areaOn), .areaColor(areaColor), .pixValid(pixValid), .pixSel(pixSel),
        .pixCode(pixCode), .pixRgb(pixRgb), .rowMode(rowMode), .rowPitch(rowPitch));
    osdco_video_sink sink_u (.clk(clk), .rst_n(rst_n), .pixValid(pixValid),
        .pixCount(pixCount));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Master holds everything until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            err_count++;
            results();
        end
    endtask

    task automatic mdl(input logic [31:0] v, output logic [27:0] x);
        logic [3:0] rw;
        logic [5:0] sl, md, pt;
        logic [2:0] cd;
        logic c, u, fr, sm, cc;
        rw = v[3:0];
        c = v[13] & v[30];
        u = v[18] & v[31];
        md = csz[rw] == 0 ? OSDCO_ROW_OFF : csz[rw] == 1 ? OSDCO_ROW_LARGE :
             csz[rw] == 3 ? (tallRows[rw] ? OSDCO_ROW_TALL : OSDCO_ROW_SMALL) :
             (dblRows[rw] ? OSDCO_ROW_DOUBLE : OSDCO_ROW_MEDIUM);
        pt = csz[rw] == 0 ? 6'h09 : csz[rw] == 1 ? 6'h24 :
             csz[rw] == 3 ? (tallRows[rw] ? 6'h1a : 6'h09) : 6'h12;
        fr = frRows[rw] && !c && !u && ((v[14] && !v[11]) || (v[15] && !v[12]) ||
             (v[16] && !(v[10] && v[8:4] == 5'h1f)) ||
             (v[17] && !(v[9] && v[8:4] == 5'h00)));
        sm = smoothOn && csz[rw] != 3 && !v[19] && (v[14] | v[15]) && (v[16] | v[17]);
        cc = 1'b1;
        cd = 3'h0;
        if (csz[rw] == 0) begin
            sl = v[26] ? OSDCO_PIX_AREA : OSDCO_PIX_VIDEO;
            cd = v[29:27];
            cc = v[26];
        end else if (c || u) begin
            sl = OSDCO_PIX_CHAR;
            cd = v[22:20];
        end else if (fr) begin
            sl = OSDCO_PIX_FRINGE;
            cd = fcol;
        end else if (sm) begin
            sl = OSDCO_PIX_SMOOTH;
            cd = v[22:20];
        end else if (scrBg && v[25]) begin
            sl = OSDCO_PIX_BACK;
            cd = selBg ? {v[23], v[24], 1'b0} : bcol;
        end else if (v[25] && v[26]) begin
            sl = OSDCO_PIX_AREA;
            cd = v[29:27];
        end else begin
            sl = OSDCO_PIX_VIDEO;
            cc = 1'b0;
        end
        x = {1'b1, cc, sl, 5'h0, cd, md, pt};
    endtask

    // One dot per edge; a result appears one edge after it is driven and is checked on the edge after that
    task automatic step(input logic idle);
        @(posedge clk);
        if (expQ.size() == 2) begin
            e = expQ.pop_front();
            chk(pixValid, e[27]);
            if (e[27]) begin
                chk(pixSel, e[25:20]);
                chk(rowMode, e[11:6]);
                chk(rowPitch, e[5:0]);
                if (e[26]) chk({pixCode, pixRgb}, {e[14:12], pal[e[14:12]]});
            end
        end
        r = rnd();
        r[3:0] = r[3:0] % 12;
        if (smoothOn && r[3:0] == 4'h8) r[3:0] = 4'h9;
        if (frRows[r[3:0]]) r[19] = 1'b0;
        if (idle) e = '0;
        else mdl(r, e);
        if (!idle) sent++;
        expQ.push_back(e);
        dotValid <= !idle;
        {dotCol, dotRow} <= {r[8:4], r[3:0]};
        {cellBottom, cellTop, cellRight, cellLeft} <= r[12:9];
        {glyphC, glyphW, glyphE, glyphS, glyphN} <= {r[13] & r[30], r[17:14]};
        {ulineDot, colorFont, charColor} <= {r[18] & r[31], r[19], r[22:20]};
        {charBgEnable, underlineAttr, slantAttr} <= r[25:23];
        {areaColor, areaOn} <= r[29:26];
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        logic [7:0] ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                                 8'h1c, 8'h20, 8'h40};
        logic [31:0] msk [10] = '{32'h10, 32'hff, 32'h0f, 32'h77, 32'hfff, 32'hfff,
                                  32'h80, 32'h08, 32'hffffff, 32'h3f};
        logic [31:0] w;
        seed = 32'h100e392f;
        {err_count, n_checks, sent} = '0;
        {smoothOn, scrBg, selBg, frRows, dblRows, tallRows} = '0;
        {avs_read, avs_write, avs_address, avs_writedata, dotValid, rst_n} = '0;
        r = '0;
        step(1'b1);
        @(posedge clk);
        rst_n <= 1'b1;
        expQ.delete();
        @(posedge clk);
        chk({avs_waitrequest, pixValid, rowMode, rowPitch}, {2'b10, 6'h01, 6'h09});
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, ofs[i], 32'h0);
            chk(q, 32'h0);
            w = rnd();
            bus(1'b1, ofs[i], w);
            bus(1'b0, ofs[i], 32'h0);
            chk(q & msk[i], w & msk[i]);
        end
        bus(1'b1, 8'h30, 32'hffffffff);
        bus(1'b0, 8'h30, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 8; i++) begin
            w = rnd();
            pal[i] = w[5:0];
            bus(1'b1, `OSDCO_OFS_PALETTE + 8'(4 * i), {26'h0, pal[i]});
        end
        w = 0;
        for (int i = 0; i < 12; i++) w[2*i+:2] = 2'(csz[i]);
        bus(1'b1, `OSDCO_OFS_ROW_SIZE, w);
        {dblRows, tallRows, frRows} = {12'h120, 12'h208, 12'h40b};
        bus(1'b1, `OSDCO_OFS_DOUBLE, {20'h0, dblRows});
        bus(1'b1, `OSDCO_OFS_TALL, {20'h0, tallRows});
        bus(1'b1, `OSDCO_OFS_FRINGE_LOW, {24'h0, frRows[7:0]});
        bus(1'b1, `OSDCO_OFS_FRINGE_HIGH, {28'h0, frRows[11:8]});
        for (int p = 0; p < 8; p++) begin
            w = rnd();
            {smoothOn, scrBg, selBg, fcol, bcol} = {p[2:0], w[2:0], w[6:4]};
            bus(1'b1, `OSDCO_OFS_COLOR, {25'h0, bcol, 1'b0, fcol});
            bus(1'b1, `OSDCO_OFS_RASTER, {24'h0, scrBg, 7'h0});
            bus(1'b1, `OSDCO_OFS_DISPLAY, {28'h0, selBg, 3'h0});
            bus(1'b1, `OSDCO_OFS_ORNAMENT, {27'h0, smoothOn, 4'h0});
            expQ.delete();
            for (int k = 0; k < 400; k++) step(rnd() % 5 == 0);
            step(1'b1);
            step(1'b1);
        end
        @(posedge clk);
        chk(pixCount, sent);
        results();
    end
endmodule
